// ### logic/ucs_map.svh
// offsets, field positions, reset values and timing counts of the command status block
`ifndef UCS_MAP_SVH
`define UCS_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define UCS_CS_OFFSET 8'h08
`define UCS_CS_RESET 32'h00000000
`define UCS_SOC_RESET 2'h0

// ----------------------------------------
// field positions of command_status
// ----------------------------------------
`define UCS_HCR_BIT 0
`define UCS_CLF_BIT 1
`define UCS_BLF_BIT 2
`define UCS_OCR_BIT 3
`define UCS_SOC_LO 16
`define UCS_SOC_HI 17

// ----------------------------------------
// timing
// ----------------------------------------
`define UCS_CLK_MHZ 20
`define UCS_SR_TIME_US 10
// longest time rounds down to whole cycles
`define UCS_SR_CYCLES (`UCS_SR_TIME_US * `UCS_CLK_MHZ)
// cycles spent around the hold count: start capture and bit clear
`define UCS_SR_LEAD 2

`endif

// ### logic/ucs_pkg.sv
// types shared by the command status block
package ucs_pkg;

	// ----------------------------------------
	// register access request
	// ----------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} ucs_reg_req_t;

	// ----------------------------------------
	// list engine events, one set per list
	// ----------------------------------------
	typedef struct packed {
		logic start;
		logic td_found;
	} ucs_list_evt_t;

	// soft reset sequencer states
	typedef enum logic [0:0] {
		UCS_SR_IDLE,
		UCS_SR_HOLD
	} ucs_sr_state_t;

endpackage

// ### logic/ucs_soft_reset_seq.sv
// soft reset hold timer: busy for a fixed count, then one done pulse
`timescale 1ns/1ns
`include "ucs_map.svh"

module ucs_soft_reset_seq
	import ucs_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = `UCS_SR_CYCLES - `UCS_SR_LEAD
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_start,
	output logic o_busy,
	output logic o_done
);

	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

	ucs_sr_state_t state_ff;
	logic [CW-1:0] cnt_ff;
	logic done_ff;

	// ----------------------------------------
	// state and counter
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_ff <= UCS_SR_IDLE;
			cnt_ff <= '0;
		end else if (i_start) begin
			state_ff <= UCS_SR_HOLD; // a new request restarts the hold
			cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				UCS_SR_IDLE: begin
					cnt_ff <= '0;
				end
				UCS_SR_HOLD: begin
					if (cnt_ff == LAST) begin
						state_ff <= UCS_SR_IDLE;
					end
					cnt_ff <= cnt_ff + CW'(1);
				end
			endcase
		end
	end

	// one-cycle completion pulse
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (state_ff == UCS_SR_HOLD) && (cnt_ff == LAST) && !i_start;
		end
	end

	assign o_busy = (state_ff == UCS_SR_HOLD);
	assign o_done = done_ff;

endmodule

// ### logic/ucs_cmd_status.sv
// command_status register of the host controller with its hardware handshakes
`timescale 1ns/1ns
`include "ucs_map.svh"

module ucs_cmd_status
	import ucs_pkg::*;
#(
	parameter bit SMI_PRESENT = 1'b1,
	parameter int unsigned SR_HOLD_CYCLES = `UCS_SR_CYCLES - `UCS_SR_LEAD
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_B,
	input wire ucs_reg_req_t I_REG_REQ,
	input wire ucs_list_evt_t [1:0] I_LIST_EVT,
	input wire logic I_OVERRUN,
	input wire logic I_OWNER_CHANGED,
	input wire logic I_OC_UNMASKED,
	output logic [31:0] O_REG_RDATA,
	output logic O_REG_RVALID,
	output logic [1:0] O_LIST_FILLED,
	output logic [1:0] O_LIST_GO,
	output logic [1:0] O_LIST_SKIP,
	output logic O_OWN_REQ,
	output logic [1:0] O_SOC,
	output logic O_SO_SET,
	output logic O_OC_SET,
	output logic O_SMI_REQ,
	output logic O_SOFT_RESET,
	output logic O_ENTER_SUSPEND,
	output logic O_HOST_BUS_HOLD
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic wr_hit;
	logic rd_hit;
	logic [31:0] wdata;
	logic sr_start;
	logic sr_busy;
	logic sr_done;
	logic own_set;

	// access hits only the command_status offset
	assign wr_hit = I_REG_REQ.wr && (I_REG_REQ.addr == `UCS_CS_OFFSET);
	assign rd_hit = I_REG_REQ.rd && (I_REG_REQ.addr == `UCS_CS_OFFSET);
	assign wdata = I_REG_REQ.wdata;
	assign own_set = wr_hit && wdata[`UCS_OCR_BIT];

	// ----------------------------------------
	// soft reset
	// ----------------------------------------
	logic hcr_ff;
	logic nxt_hcr;
	logic susp_ff;
	logic hold_ff;

	// a start is taken when idle or in the cycle the previous one completes
	assign sr_start = wr_hit && wdata[`UCS_HCR_BIT] && (!hcr_ff || sr_done);

	ucs_soft_reset_seq #(
		.HOLD_CYCLES(SR_HOLD_CYCLES)
	) u_sr_seq (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_start(sr_start),
		.o_busy(sr_busy),
		.o_done(sr_done)
	);

	// set by software, cleared by the hold timer; a fresh set wins
	always_comb begin
		nxt_hcr = hcr_ff;
		if (sr_done) begin
			nxt_hcr = 1'b0;
		end
		if (sr_start) begin
			nxt_hcr = 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			hcr_ff <= 1'b0;
		end else begin
			hcr_ff <= nxt_hcr;
		end
	end

	// suspend entry pulse once per reset request
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			susp_ff <= 1'b0;
		end else begin
			susp_ff <= sr_start;
		end
	end

	// host bus accesses blocked for the whole reset
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			hold_ff <= 1'b0;
		end else begin
			hold_ff <= nxt_hcr;
		end
	end

	// operational registers only; routing, root hub and ports untouched
	assign O_SOFT_RESET = hcr_ff;
	assign O_ENTER_SUSPEND = susp_ff;
	assign O_HOST_BUS_HOLD = hold_ff;

	// ----------------------------------------
	// ownership change
	// ----------------------------------------
	logic own_ff;
	logic oc_ff;
	logic smi_ff;

	// request stays until the changeover; a new write wins over it
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			own_ff <= 1'b0;
		end else if (own_set) begin
			own_ff <= 1'b1;
		end else if (I_OWNER_CHANGED) begin
			own_ff <= 1'b0;
		end
	end

	// flag pulse into interrupt_status, forced low without the pin
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			oc_ff <= 1'b0;
		end else begin
			oc_ff <= own_set && SMI_PRESENT;
		end
	end

	// management interrupt raised in the same step as the flag
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			smi_ff <= 1'b0;
		end else begin
			smi_ff <= own_set && SMI_PRESENT && I_OC_UNMASKED;
		end
	end

	assign O_OWN_REQ = own_ff;
	assign O_OC_SET = oc_ff;
	assign O_SMI_REQ = smi_ff;

	// ----------------------------------------
	// scheduling overrun count
	// ----------------------------------------
	logic [1:0] soc_ff;
	logic so_ff;

	// counts overruns and wraps; cleared by a soft reset start, which also drops an overrun in the same cycle
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			soc_ff <= `UCS_SOC_RESET;
		end else if (sr_start) begin
			soc_ff <= `UCS_SOC_RESET;
		end else if (I_OVERRUN) begin
			soc_ff <= soc_ff + 2'h1;
		end
	end

	// overrun flag pulse into interrupt_status
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			so_ff <= 1'b0;
		end else begin
			so_ff <= I_OVERRUN;
		end
	end

	assign O_SOC = soc_ff;
	assign O_SO_SET = so_ff;

	// ----------------------------------------
	// list filled bits: 0 control, 1 bulk
	// ----------------------------------------
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_list
			logic filled_ff;
			logic nxt_filled;
			logic go_ff;
			logic skip_ff;
			logic sw_set;

			assign sw_set = wr_hit && wdata[`UCS_CLF_BIT + k];

			// soft reset, engine clear, engine refill, then software set
			always_comb begin
				nxt_filled = filled_ff;
				if (sr_start) begin
					nxt_filled = 1'b0;
				end
				if (I_LIST_EVT[k].start && filled_ff && !hcr_ff) begin
					nxt_filled = 1'b0;
				end
				if (I_LIST_EVT[k].td_found) begin
					nxt_filled = 1'b1;
				end
				if (sw_set) begin
					nxt_filled = 1'b1;
				end
			end

			always_ff @(posedge I_SYS_CLK) begin
				if (!I_RST_B) begin
					filled_ff <= 1'b0;
				end else begin
					filled_ff <= nxt_filled;
				end
			end

			// answer to a list start: process or skip, none during reset
			always_ff @(posedge I_SYS_CLK) begin
				if (!I_RST_B) begin
					go_ff <= 1'b0;
					skip_ff <= 1'b0;
				end else begin
					go_ff <= I_LIST_EVT[k].start && filled_ff && !hcr_ff;
					skip_ff <= I_LIST_EVT[k].start && !filled_ff && !hcr_ff;
				end
			end

			assign O_LIST_FILLED[k] = filled_ff;
			assign O_LIST_GO[k] = go_ff;
			assign O_LIST_SKIP[k] = skip_ff;

			a_list_skip: assert property (
				@(posedge I_SYS_CLK) disable iff (!I_RST_B)
				I_LIST_EVT[k].start && !filled_ff && !hcr_ff
				|=> O_LIST_SKIP[k] && !O_LIST_GO[k]
			) else $error("empty list start did not skip");

			a_list_clear: assert property (
				@(posedge I_SYS_CLK) disable iff (!I_RST_B)
				I_LIST_EVT[k].start && filled_ff && !hcr_ff && !sw_set
				&& !I_LIST_EVT[k].td_found
				|=> O_LIST_GO[k] && !O_LIST_FILLED[k]
			) else $error("filled list start did not process and clear");

			a_list_refill: assert property (
				@(posedge I_SYS_CLK) disable iff (!I_RST_B)
				I_LIST_EVT[k].td_found |=> O_LIST_FILLED[k]
			) else $error("found descriptor did not refill list bit");
		end
	endgenerate

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic [31:0] cs_value;

	// reserved bits are not stored and read as zero
	always_comb begin
		cs_value = `UCS_CS_RESET;
		cs_value[`UCS_HCR_BIT] = hcr_ff;
		cs_value[`UCS_CLF_BIT] = g_list[0].filled_ff;
		cs_value[`UCS_BLF_BIT] = g_list[1].filled_ff;
		cs_value[`UCS_OCR_BIT] = own_ff;
		cs_value[`UCS_SOC_HI:`UCS_SOC_LO] = soc_ff;
	end

	// read answer one cycle after the request; other offsets read zero
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_B) begin
			rdata_ff <= `UCS_CS_RESET;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= rd_hit ? cs_value : `UCS_CS_RESET;
			rvalid_ff <= I_REG_REQ.rd;
		end
	end

	assign O_REG_RDATA = rdata_ff;
	assign O_REG_RVALID = rvalid_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_write_sets: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		wr_hit && wdata[`UCS_BLF_BIT] |=> O_LIST_FILLED[1]
	) else $error("written one did not set bulk filled");

	a_write_keeps: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		wr_hit && !wdata[`UCS_OCR_BIT] && O_OWN_REQ && !I_OWNER_CHANGED |=> O_OWN_REQ
	) else $error("written zero disturbed ownership request");

	a_read_value: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		rd_hit |=> O_REG_RVALID
		&& O_REG_RDATA[`UCS_SOC_HI:`UCS_SOC_LO] == $past(soc_ff)
		&& O_REG_RDATA[`UCS_OCR_BIT] == $past(own_ff)
		&& O_REG_RDATA[`UCS_HCR_BIT] == $past(hcr_ff)
	) else $error("read data does not match register state");

	a_soc_count: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		I_OVERRUN && !sr_start |=> O_SOC == 2'($past(soc_ff) + 2'h1)
	) else $error("overrun counter did not step and wrap");

	a_soc_start: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		$past(!I_RST_B) |-> O_SOC == `UCS_SOC_RESET
	) else $error("overrun counter not zero after reset");

	a_so_flag: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		I_OVERRUN |=> O_SO_SET ##1 (O_SO_SET == $past(I_OVERRUN))
	) else $error("overrun flag pulse missing");

	a_soc_hold: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		!I_OVERRUN && !sr_start |=> O_SOC == $past(soc_ff)
	) else $error("overrun counter moved without overrun");

	a_oc_flag: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		own_set |=> O_OWN_REQ && (O_OC_SET == SMI_PRESENT)
	) else $error("ownership request did not raise flag");

	a_own_clear: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		I_OWNER_CHANGED && !own_set ##1 !own_set |=> !O_OWN_REQ
	) else $error("ownership request not cleared after changeover");

	a_smi_raise: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		O_SMI_REQ |-> O_OC_SET && SMI_PRESENT && $past(I_OC_UNMASKED)
	) else $error("management interrupt without unmasked ownership change");

	a_sr_suspend: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		sr_start |=> O_ENTER_SUSPEND && O_SOFT_RESET && O_HOST_BUS_HOLD
	) else $error("soft reset did not enter suspend");

	a_sr_no_bus: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		O_SOFT_RESET |=> O_LIST_GO == 2'h0
	) else $error("list processed during soft reset");

	a_sr_bound: assert property (
		@(posedge I_SYS_CLK) disable iff (!I_RST_B)
		$rose(O_SOFT_RESET) |-> ##[1:199] (!O_SOFT_RESET || sr_start)
	) else $error("soft reset exceeded its time limit");

endmodule

// ### testbench/test_ucs_cmd_status.sv
// self-checking bench of the command status register block
`timescale 1ns/1ns
`include "ucs_map.svh"

module test_ucs_cmd_status
	import ucs_pkg::*;
;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	localparam int HOLD = 4;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	ucs_reg_req_t req = '0;
	ucs_list_evt_t [1:0] evt = '0;
	logic ovr = 1'h0;
	logic own_chg = 1'h0;
	logic oc_unm = 1'h0;
	logic [31:0] rdata;
	logic rvalid;
	logic [1:0] filled;
	logic [1:0] go;
	logic [1:0] skip;
	logic [1:0] soc;
	logic own_req;
	logic so_set;
	logic oc_set;
	logic smi_req;
	logic soft_rst;
	logic enter_susp;
	logic bus_hold;
	int fail_count = 0;
	int n_compared = 0;
	int cnt;
	logic [1:0] int_flags = 2'h0;
	logic [1:0] int_clr;

	// 20 MHz clock
	always #25 clk = ~clk;

	// device under test with a short soft reset hold
	ucs_cmd_status #(
		.SMI_PRESENT(1'h1),
		.SR_HOLD_CYCLES(HOLD)
	) ucs_cmd_status_inst (
		.I_SYS_CLK(clk),
		.I_RST_B(rst_b),
		.I_REG_REQ(req),
		.I_LIST_EVT(evt),
		.I_OVERRUN(ovr),
		.I_OWNER_CHANGED(own_chg),
		.I_OC_UNMASKED(oc_unm),
		.O_REG_RDATA(rdata),
		.O_REG_RVALID(rvalid),
		.O_LIST_FILLED(filled),
		.O_LIST_GO(go),
		.O_LIST_SKIP(skip),
		.O_OWN_REQ(own_req),
		.O_SOC(soc),
		.O_SO_SET(so_set),
		.O_OC_SET(oc_set),
		.O_SMI_REQ(smi_req),
		.O_SOFT_RESET(soft_rst),
		.O_ENTER_SUSPEND(enter_susp),
		.O_HOST_BUS_HOLD(bus_hold)
	);

	// interrupt_status flags kept outside the block: 0 overrun, 1 ownership
	assign int_clr = (req.wr && req.addr == 8'h0C) ? {req.wdata[30], req.wdata[0]} : 2'h0;
	always @(posedge clk) begin
		int_flags <= (int_flags & ~int_clr) | {oc_set, so_set};
	end

	// ----------------------------------------
	// helper tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one write cycle, returns where its effect is settled
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'h0, 1'h1, a, d};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
	endtask

	// one read cycle, data checked in the valid cycle
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		req <= '{1'h1, 1'h0, a, 32'h0};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		chk(rvalid, 32'h1, "read valid");
		chk(rdata, exp, what);
	endtask

	// list engine pulse on list i
	task automatic list_evt(input int i, input logic st, input logic td);
		@(posedge clk);
		evt[i].start <= st;
		evt[i].td_found <= td;
		@(posedge clk);
		evt[i] <= '0;
		@(negedge clk);
	endtask

	// overrun (0) or changeover (1) pulse
	task automatic hw_evt(input int which);
		@(posedge clk);
		if (which == 0) begin
			ovr <= 1'h1;
		end else begin
			own_chg <= 1'h1;
		end
		@(posedge clk);
		ovr <= 1'h0;
		own_chg <= 1'h0;
		@(negedge clk);
	endtask

	task automatic summarize;
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		@(negedge clk);
		chk({filled, go, skip, soc, own_req, so_set, oc_set, soft_rst}, 32'h0, "reset outs");
		rd_reg(8'h08, 32'h0, "reset value");
		// write-to-set keeps earlier commands
		wr_reg(8'h08, 32'h4);
		chk(filled, 32'h2, "bulk set");
		wr_reg(8'h08, 32'h2);
		chk(filled, 32'h3, "control set");
		wr_reg(8'h08, 32'h0);
		wr_reg(8'h08, 32'hFFFC_FFF0);
		rd_reg(8'h08, 32'h6, "zeros and reserved");
		wr_reg(8'h0C, 32'h8);
		chk(own_req, 32'h0, "unmapped write");
		rd_reg(8'h0C, 32'h0, "unmapped read");
		// start when filled, start when empty, descriptor found
		for (int i = 0; i < 2; i++) begin
			list_evt(i, 1'h1, 1'h0);
			chk({go[i], filled[i]}, 32'h2, "go clears filled");
			list_evt(i, 1'h1, 1'h0);
			chk({go[i], skip[i]}, 32'h1, "skip when empty");
			list_evt(i, 1'h0, 1'h1);
			chk(filled[i], 32'h1, "refilled");
		end
		// software set in the same cycle as the hardware clear
		@(posedge clk);
		req <= '{1'h0, 1'h1, 8'h08, 32'h2};
		evt[0].start <= 1'h1;
		@(posedge clk);
		req <= '0;
		evt[0] <= '0;
		@(negedge clk);
		chk({go[0], filled[0]}, 32'h3, "set beats clear");
		// five overruns wrap the counter through 3 back to 1
		for (int k = 1; k <= 5; k++) begin
			hw_evt(0);
			chk({so_set, soc}, {29'h0, 1'h1, 2'(k)}, "overrun count");
		end
		rd_reg(8'h08, 32'h0001_0006, "count in register");
		chk(int_flags, 32'h1, "overrun flag held while counting");
		wr_reg(8'h0C, 32'h0000_0001);
		chk(int_flags, 32'h0, "overrun flag cleared by one");
		// ownership request with management interrupt enabled
		@(posedge clk);
		oc_unm <= 1'h1;
		wr_reg(8'h08, 32'h8);
		chk({own_req, oc_set, smi_req}, 32'h7, "owner request");
		hw_evt(1);
		chk(own_req, 32'h0, "owner cleared");
		chk(int_flags, 32'h2, "ownership flag held");
		rd_reg(8'h08, 32'h0001_0006, "stays clear");
		@(posedge clk);
		oc_unm <= 1'h0;
		wr_reg(8'h08, 32'h8);
		chk({oc_set, smi_req}, 32'h2, "masked request");
		// soft reset: suspend, clears, no list work, bounded length
		wr_reg(8'h08, 32'h1);
		chk({soft_rst, bus_hold, enter_susp, filled, soc, own_req}, 32'hE1, "reset entry");
		list_evt(1, 1'h1, 1'h0);
		chk({go, skip}, 32'h0, "no list work");
		cnt = 0;
		repeat (20) begin
			if (soft_rst === 1'h1) begin
				cnt++;
			end
			chk(bus_hold, soft_rst, "hold tracks reset");
			chk(enter_susp, 32'h0, "suspend pulse ends");
			@(negedge clk);
		end
		chk(cnt, HOLD - 1, "reset length");
		rd_reg(8'h08, 32'h8, "after reset");
		summarize();
	end

	// watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		summarize();
	end

endmodule
